// ==== testbench/lmc_misc_bank_assertions.sv ====
`timescale 1ns/1ps
module lmc_misc_bank_assertions (
  input wire        core_clk,
  input wire        arst_n,
  input wire        cfg_wr,
  input wire        cfg_rd,
  input wire [7:0]  cfg_addr,
  input wire [15:0] cfg_wdata,
  input wire [1:0]  cfg_be,
  input wire [15:0] cfg_rdata,
  input wire        speaker_strap_pin,
  input wire        legacy_bus_pull_enable,
  input wire        pci_pullup_enable,
  input wire        disk_pulldown_enable,
  input wire        bios_to_legacy_bus,
  input wire        processor_ready_in,
  input wire        ready_pin_function_select,
  input wire        interval_timer_stop,
  input wire        rtc_stop,
  input wire        inactivity_timer_stop,
  input wire        pm_timer_stop
);
  // One domain, so one clock and reset for all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire strap_wr = cfg_wr && cfg_addr == 8'h48 && cfg_be[1];
  wire any_stop = interval_timer_stop | rtc_stop | inactivity_timer_stop | pm_timer_stop;
  a_isa_pull_wr: assert property (strap_wr |=>
    legacy_bus_pull_enable == $past(cfg_wdata[11])) else $error("legacy pull enable wrong");
  a_pci_pull_wr: assert property (strap_wr |=>
    pci_pullup_enable == $past(cfg_wdata[12])) else $error("pci pull enable wrong");
  a_disk_pull_wr: assert property (strap_wr |=>
    disk_pulldown_enable == $past(cfg_wdata[13])) else $error("disk pull enable wrong");
  a_strap_reset_load: assert property ($rose(arst_n) |=>
    {disk_pulldown_enable, pci_pullup_enable, legacy_bus_pull_enable}
    == {3{$past(speaker_strap_pin)}}) else $error("pull enables not strapped");
  a_bios_read_only: assert property (cfg_wr && cfg_addr == 8'h48 |=>
    $stable(bios_to_legacy_bus)) else $error("bios route changed by write");
  a_freeze_gated: assert property (!ready_pin_function_select |-> !any_stop)
    else $error("freeze active without ready function");
  a_freeze_ready: assert property (any_stop |-> processor_ready_in)
    else $error("freeze active without ready input");
  a_rsvd_read_zero: assert property (cfg_rd && cfg_addr == 8'h4c |=>
    cfg_rdata[15:5] == 11'h000) else $error("reserved freeze bits set");
  a_unmapped_zero: assert property (cfg_rd && !(cfg_addr inside {8'h48, 8'h4a, 8'h4c,
    8'h4e}) |=> cfg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved without a read");
endmodule // lmc_misc_bank_assertions
bind lmc_misc_bank lmc_misc_bank_assertions lmc_misc_bank_assertions_inst (.core_clk, .arst_n,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata, .speaker_strap_pin,
  .legacy_bus_pull_enable, .pci_pullup_enable, .disk_pulldown_enable, .bios_to_legacy_bus,
  .processor_ready_in, .ready_pin_function_select, .interval_timer_stop, .rtc_stop,
  .inactivity_timer_stop, .pm_timer_stop);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 0, arst_n = 0, cfg_wr = 0, cfg_rd = 0, clk32k_tick = 0, slv_low = 0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, rv;
  logic [1:0]  cfg_be = 2'h0;
  logic        bios_route_strap = 1, speaker_strap_pin = 1, rom_keyboard_select_pin = 0;
  logic        chan_ready_strap_pin = 1, processor_ready_in = 0, ready_pin_function_select = 0;
  logic        square_pin_function_select = 0, sirq_out, sirq_oe_n, sirq_busy, rtc_interrupt_pin;
  logic        legacy_bus_pull_enable, pci_pullup_enable, disk_pulldown_enable, bios_to_legacy_bus;
  logic        interval_timer_stop, rtc_stop, inactivity_timer_stop, pm_timer_stop;
  wire         sirq_in = sirq_oe_n ? !slv_low : sirq_out; // Pulled-up shared line
  int          err_count = 0, n_checks = 0, cyc = 0, n, t, k;
  int          sq [3] = '{0, 3, 4};
  int          te [3] = '{0, 16, 8};
  // Rows: address, write data, lanes, expected read-back
  logic [41:0] rows [8] = '{{8'h4a, 16'hffff, 2'h1, 16'h007f}, {8'h4a, 16'h0011, 2'h1, 16'h0011},
    {8'h4c, 16'hffff, 2'h1, 16'h001f}, {8'h4e, 16'h00ff, 2'h1, 16'h000f},
    {8'h48, 16'hffff, 2'h3, 16'h382d}, {8'h48, 16'h0000, 2'h3, 16'h0001},
    {8'h48, 16'hffff, 2'h1, 16'h002d}, {8'h50, 16'hffff, 2'h3, 16'h0000}};
  lmc_misc_bank lmc_misc_bank_inst (.core_clk, .arst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .cfg_be, .cfg_rdata, .bios_route_strap, .speaker_strap_pin, .rom_keyboard_select_pin,
    .chan_ready_strap_pin, .legacy_bus_pull_enable, .pci_pullup_enable, .disk_pulldown_enable,
    .bios_to_legacy_bus, .clk32k_tick, .processor_ready_in, .ready_pin_function_select,
    .interval_timer_stop, .rtc_stop, .inactivity_timer_stop, .pm_timer_stop,
    .square_pin_function_select, .rtc_interrupt_pin, .sirq_in, .sirq_out, .sirq_oe_n, .sirq_busy);
  // Slow tick scaled to 8 core cycles so square tests stay short
  always #2.5 core_clk = ~core_clk;
  always #20 clk32k_tick = ~clk32k_tick;
  // Hang guard, well above the fewer than two thousand cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task rst;
    arst_n = 0;
    repeat (2) step;
    arst_n = 1;
    step;
  endtask
  // Request held one full edge, dropped just after it
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = b;
    cfg_wr = 1;
    step;
    cfg_wr = 0;
    step;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    cfg_addr = a;
    cfg_rd = 1;
    step;
    cfg_rd = 0;
    d = cfg_rdata;
    step;
  endtask
  task wait_low(output int c);
    c = 0;
    while (!(sirq_oe_n === 0 && sirq_out === 0) && c < 300) begin c++; step; end
  endtask
  task low_run(output int c);
    c = 0;
    while (sirq_oe_n === 0 && sirq_out === 0 && c < 20) begin c++; step; end
  endtask
  task idle_wait;
    t = 0;
    while (sirq_busy !== 0 && t < 400) begin t++; step; end
    chk(t < 400, 1);
  endtask
  initial begin
    rst;
    rd(8'h48, rv); chk(rv, 16'h3821);
    rd(8'h4a, rv); chk(rv, 16'h0010);
    rd(8'h4c, rv); chk(rv, 16'h0000);
    rd(8'h4e, rv); chk(rv, 16'h0000);
    chk({legacy_bus_pull_enable, pci_pullup_enable, disk_pulldown_enable, bios_to_legacy_bus},
      4'hf);
    $display("reset values test done");
    foreach (rows[i]) begin
      wr(rows[i][41:34], rows[i][33:18], rows[i][17:16]);
      rd(rows[i][41:34], rv); chk(rv, rows[i][15:0]);
    end
    $display("register table test done");
    wr(8'h4c, 16'h001f, 2'h1);
    for (int i = 0; i < 4; i++) begin
      {ready_pin_function_select, processor_ready_in} = i[1:0];
      step;
      chk({pm_timer_stop, inactivity_timer_stop, rtc_stop, interval_timer_stop}, {4{i == 3}});
    end
    wr(8'h4c, 16'h0004, 2'h1);
    chk({pm_timer_stop, inactivity_timer_stop, rtc_stop, interval_timer_stop}, 4'h0);
    wr(8'h4c, 16'h0001, 2'h1);
    chk({pm_timer_stop, inactivity_timer_stop, rtc_stop, interval_timer_stop}, 4'h1);
    $display("freeze test done");
    square_pin_function_select = 1;
    foreach (sq[i]) begin
      wr(8'h4e, sq[i][15:0], 2'h1);
      repeat (64) step;
      n = 0;
      repeat (256) begin k = rtc_interrupt_pin; step; n += (k != rtc_interrupt_pin); end
      chk(n >= te[i] - 1 && n <= te[i] + 1, 1);
    end
    wr(8'h4e, 16'h0000, 2'h1);
    repeat (64) step;
    chk(rtc_interrupt_pin, 0);
    $display("square wave test done");
    for (int w = 0; w < 3; w++) begin
      wr(8'h4a, 16'h0000, 2'h1);
      idle_wait;
      wr(8'h4a, 16'h0040 | w | (w == 2 ? 16'h003c : 16'h0000), 2'h1);
      wait_low(t); low_run(n); chk(n, 4 + 2 * w);
      wait_low(t); chk(t, 2 + (17 + (w == 2 ? 15 : 0)) * 3);
      low_run(n); wait_low(t); chk(t < 10, 1);
    end
    wr(8'h4a, 16'h0000, 2'h1);
    idle_wait;
    k = 0;
    repeat (100) begin step; k += (sirq_oe_n === 0); end
    chk(k, 0);
    slv_low = 1;
    step;
    slv_low = 0;
    wait_low(t); low_run(n); chk(n, 3);
    $display("serial irq test done");
    {speaker_strap_pin, bios_route_strap, rom_keyboard_select_pin, chan_ready_strap_pin} = 4'h2;
    rst;
    rd(8'h48, rv); chk(rv, 16'h0008);
    $display("second reset test done");
    print_verdict;
  end
endmodule // tb_top

// ==== verilog/lmc_consts.vh ====
`ifndef LMC_CONSTS_VH
`define LMC_CONSTS_VH
// Register offsets in function 3 configuration space
`define LMC_OFS_STRAP   8'h48
`define LMC_OFS_SIRQ    8'h4a
`define LMC_OFS_FREEZE  8'h4c
`define LMC_OFS_SQW     8'h4e
// Strap register field positions
`define LMC_BIT_BIOS    0
`define LMC_BIT_KLO     3
`define LMC_BIT_KHI     5
`define LMC_BIT_ISAPU   11
`define LMC_BIT_PCIPU   12
`define LMC_BIT_IDEPD   13
// Reset values
`define LMC_RST_SIRQ    8'h10
`define LMC_RST_FREEZE  8'h00
`define LMC_RST_SQW     8'h00
// Writable masks
`define LMC_WM_STRAP    16'h382c
`define LMC_WM_SIRQ     8'h7f
`define LMC_WM_FREEZE   8'h1f
`define LMC_WM_SQW      8'h0f
// Serial IRQ timing
`define LMC_FRAME_CLKS  2'd3
`define LMC_FRAME_BASE  6'd17
`define LMC_STOP_CLKS   3'd2
// 32 kHz divider width
`define LMC_DIV_W       14
`endif

// ==== verilog/lmc_misc_bank.v ====
`timescale 1ns/1ps
// Overview of operation
// R1 - Strap bits load from pin levels when power-good reset releases.
// R2 - Three pad resistor enables default from the speaker strap pin.
// R3 - Bit 0 is read-only bios route strap: 1 legacy bus, 0 LPC.
// R4 - Bits 3:2 writable, bit 3 default from rom select pin; keep zero.
// R5 - Bit 5 writable, default from channel-ready pin; keep one.
// R6 - Bit 11 enables legacy bus pull resistors.
// R7 - Bit 12 enables PCI control and interrupt pull-ups.
// R8 - Bit 13 enables disk DMA request pull-downs.
// R9 - Start pulse lasts 4, 6 or 8 clocks by width field.
// R10 - Each cycle has 17 plus field frames of three clocks, then stop.
// R11 - Continuous mode starts a new start frame right after each stop; here one released idle clock comes first.
// R12 - In quiet mode an external slave starts each cycle.
// R13 - Freeze enables ignored unless ready pin function selected.
// R14 - Freeze bit 0 stops the interval timers while ready active.
// R15 - Freeze bit 1 stops the 32 kHz RTC counters while ready active.
// R16 - Freeze bit 2 is plain storage controlling nothing.
// R17 - Freeze bit 3 stops the inactivity timer while ready active.
// R18 - Freeze bit 4 stops the power management timer while ready active.
// R19 - Square wave on rtc interrupt pin divides the 32 kHz clock.
// R20 - Frequency code: 0 low, 1-3 give 256,128,8192, 4..F halve 4096..2.
// R21 - Reserved bits read zero and ignore writes.
`include "lmc_consts.vh"
// Serial IRQ cycle as driven here, counted in core clocks:
//   start    low for 4, 6 or 8 clocks; in quiet mode the slave's
//            first low clock counts towards that width
//   turn     one clock driven high, then one clock released
//   frames   17 to 32 slots of three clocks, each owned by a slave
//   stop     low for two clocks, then one clock driven high
//   release  line handed back to its pull-up before any new start
// We drive high for a single clock after each low phase only to
// sharpen the rising edge, then let the pull-up hold the line.
// Continuous mode restarts one idle clock after the stop frame.
// Quiet mode sits in idle until a slave pulls the line low.
//
// Straps are taken on the first clock after reset release, so
// software must not touch the bank on that very clock.
// Bits 3:2 and 5 of the strap register are plain storage here;
// software keeps them at their required levels, we do not police it.
//
// The square divider counts rising edges of a sampled 32 kHz
// clock; that clock must be slower than half the core clock or
// edges are lost and every frequency comes out low.
// Freeze outputs are combinational so the timers stop on the
// same clock the ready input becomes active.
//
module lmc_misc_bank (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [15:0] cfg_wdata,
  input  wire [1:0]  cfg_be,
  output reg  [15:0] cfg_rdata,
  input  wire        bios_route_strap,
  input  wire        speaker_strap_pin,
  input  wire        rom_keyboard_select_pin,
  input  wire        chan_ready_strap_pin,
  output wire        legacy_bus_pull_enable,
  output wire        pci_pullup_enable,
  output wire        disk_pulldown_enable,
  output wire        bios_to_legacy_bus,
  input  wire        clk32k_tick,
  input  wire        processor_ready_in,
  input  wire        ready_pin_function_select,
  output wire        interval_timer_stop,
  output wire        rtc_stop,
  output wire        inactivity_timer_stop,
  output wire        pm_timer_stop,
  input  wire        square_pin_function_select,
  output reg         rtc_interrupt_pin,
  input  wire        sirq_in,
  output reg         sirq_out,
  output reg         sirq_oe_n,
  output reg         sirq_busy
);

  // Serial IRQ sequencer states
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_TURN  = 3'd2;
  localparam ST_FRAME = 3'd3;
  localparam ST_STOP  = 3'd4;
  localparam ST_GAP   = 3'd5;

  reg [15:0] strap_q;
  reg [7:0]  sirq_q;
  reg [7:0]  freeze_q;
  reg [7:0]  sqw_q;
  reg        load_q;
  reg [2:0]  st_q;
  reg [3:0]  cnt_q;
  reg [5:0]  frm_q;
  reg        sirq_in_q;
  reg [`LMC_DIV_W-1:0] div_q;
  reg        tick_q;

  // Named views of the register fields used by the logic
  wire [1:0] start_pulse_width       = sirq_q[1:0];
  wire [3:0] frame_extra             = sirq_q[5:2];
  wire       continuous_mode_bit     = sirq_q[6];
  wire       interval_timer_freeze   = freeze_q[0];
  wire       rtc_freeze              = freeze_q[1];
  wire       inactivity_timer_freeze = freeze_q[3];
  wire       pm_timer_freeze         = freeze_q[4];
  wire [3:0] square_freq_field       = sqw_q[3:0];

  // Merge byte-enabled write data under a writable mask
  // Read-only and reserved bits are simply absent from the mask
  function [15:0] wmerge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    input [15:0] wm;
    reg   [15:0] bm;
    begin
      bm = {{8{be[1]}}, {8{be[0]}}} & wm;
      wmerge = (old & ~bm) | (wd & bm);
    end
  endfunction

  // Start pulse length in clocks, minus one for the counter
  // Used by both the continuous and the slave-started path
  function [3:0] start_len;
    input [1:0] code;
    begin
      case (code)
        2'b00:   start_len = 4'd3;
        2'b01:   start_len = 4'd5;
        default: start_len = 4'd7; // Reserved code treated as eight
      endcase
    end
  endfunction

  // Write decode; full byte compare, so odd offsets never alias
  // onto the byte registers
  wire wr_strap  = cfg_wr && (cfg_addr == `LMC_OFS_STRAP);
  wire wr_sirq   = cfg_wr && (cfg_addr == `LMC_OFS_SIRQ);
  wire wr_freeze = cfg_wr && (cfg_addr == `LMC_OFS_FREEZE);
  wire wr_sqw    = cfg_wr && (cfg_addr == `LMC_OFS_SQW);

  // Straps are sampled on the first clock after reset release, never in reset
  // Sampling in reset would need the pins in the reset branch,
  // which an asynchronous clear must not read
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_q  <= 1'b1;
      strap_q <= 16'h0000;
    end else if (load_q) begin
      load_q  <= 1'b0;
      strap_q <= 16'h0000; // R21
      strap_q[`LMC_BIT_BIOS]  <= bios_route_strap; // R1 R3
      strap_q[`LMC_BIT_KLO]   <= rom_keyboard_select_pin; // R4
      strap_q[`LMC_BIT_KHI]   <= chan_ready_strap_pin; // R5
      strap_q[`LMC_BIT_ISAPU] <= speaker_strap_pin; // R2
      strap_q[`LMC_BIT_PCIPU] <= speaker_strap_pin; // R2
      strap_q[`LMC_BIT_IDEPD] <= speaker_strap_pin; // R2
    end else if (wr_strap) begin
      // Bit 0 excluded from the mask, so it stays read-only
      strap_q <= wmerge(strap_q, cfg_wdata, cfg_be, `LMC_WM_STRAP); // R3 R4 R5 R21
    end
  end

  // Byte registers live in the low lane
  // The high lane enable is ignored for them
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sirq_q   <= `LMC_RST_SIRQ;
      freeze_q <= `LMC_RST_FREEZE;
      sqw_q    <= `LMC_RST_SQW;
    end else begin
      if (wr_sirq && cfg_be[0])
        sirq_q <= cfg_wdata[7:0] & `LMC_WM_SIRQ; // R21
      if (wr_freeze && cfg_be[0])
        freeze_q <= cfg_wdata[7:0] & `LMC_WM_FREEZE; // R16 R21
      if (wr_sqw && cfg_be[0])
        sqw_q <= cfg_wdata[7:0] & `LMC_WM_SQW; // R21
    end
  end

  // Read data registered; unmapped offsets read zero
  // Holds its value between reads
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `LMC_OFS_STRAP:  cfg_rdata <= strap_q;
        `LMC_OFS_SIRQ:   cfg_rdata <= {8'h00, sirq_q};
        `LMC_OFS_FREEZE: cfg_rdata <= {8'h00, freeze_q};
        `LMC_OFS_SQW:    cfg_rdata <= {8'h00, sqw_q};
        default:         cfg_rdata <= 16'h0000; // R21
      endcase
    end
  end

  // Pad controls straight from the strap register
  assign legacy_bus_pull_enable = strap_q[`LMC_BIT_ISAPU]; // R6
  assign pci_pullup_enable      = strap_q[`LMC_BIT_PCIPU]; // R7
  assign disk_pulldown_enable   = strap_q[`LMC_BIT_IDEPD]; // R8
  assign bios_to_legacy_bus     = strap_q[`LMC_BIT_BIOS]; // R3

  // Freeze gating; the whole register is dead without the ready function
  // Bit 2 is deliberately left out: it drives nothing
  wire frz_on = ready_pin_function_select && processor_ready_in; // R13
  assign interval_timer_stop   = frz_on && interval_timer_freeze; // R14
  assign rtc_stop              = frz_on && rtc_freeze; // R15
  assign inactivity_timer_stop = frz_on && inactivity_timer_freeze; // R17
  assign pm_timer_stop         = frz_on && pm_timer_freeze; // R18

  // Serial IRQ frame sequencer; line is pulled up, we pull low and drive high for one clock after each low
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 4'd0;
      frm_q     <= 6'd0;
      sirq_out  <= 1'b1;
      sirq_oe_n <= 1'b1;
      sirq_busy <= 1'b0;
      sirq_in_q <= 1'b1;
    end else begin
      sirq_in_q <= sirq_in;
      case (st_q)
        ST_IDLE: begin
          sirq_oe_n <= 1'b1;
          sirq_busy <= 1'b0;
          // Continuous starts itself; quiet waits for a slave pulling low
          if (continuous_mode_bit || (!sirq_in && sirq_in_q)) begin // R11 R12
            st_q      <= ST_START;
            cnt_q     <= (continuous_mode_bit ? start_len(start_pulse_width) :
                          start_len(start_pulse_width) - 4'd1);
            sirq_out  <= 1'b0;
            sirq_oe_n <= 1'b0;
            sirq_busy <= 1'b1;
          end
        end

        // Hold the line low until the width counter runs out
        // Then drive high for one clock to speed the edge
        ST_START: begin
          if (cnt_q == 4'd0) begin // R9
            st_q     <= ST_TURN;
            sirq_out <= 1'b1;
            cnt_q    <= 4'd1;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end

        // Release the line and wait out the turnaround
        // Frame counter is loaded on leaving
        ST_TURN: begin
          sirq_oe_n <= 1'b1;
          if (cnt_q == 4'd0) begin
            st_q  <= ST_FRAME;
            frm_q <= `LMC_FRAME_BASE + {2'b00, frame_extra}; // R10
            cnt_q <= {2'b00, `LMC_FRAME_CLKS} - 4'd1;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end

        // Three clocks per slot, counted down to the last slot
        // The stop frame low starts on the clock after it
        ST_FRAME: begin
          // Slaves drive their own slots; we only count them
          if (cnt_q == 4'd0) begin
            if (frm_q == 6'd1) begin // R10
              st_q      <= ST_STOP;
              cnt_q     <= {1'b0, `LMC_STOP_CLKS} - 4'd1;
              sirq_out  <= 1'b0;
              sirq_oe_n <= 1'b0;
            end else begin
              frm_q <= frm_q - 6'd1;
              cnt_q <= {2'b00, `LMC_FRAME_CLKS} - 4'd1;
            end
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end

        // Stop frame low phase
        // Ends with one clock driven high
        ST_STOP: begin
          if (cnt_q == 4'd0) begin
            st_q     <= ST_GAP;
            sirq_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end

        // Final release before idle
        // Idle then decides whether to restart
        ST_GAP: begin
          // One drive-high clock then release and restart if continuous
          sirq_oe_n <= 1'b1;
          st_q      <= ST_IDLE; // R11
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Free-running divider on 32 kHz ticks; 2^15 Hz assumed
  // Never reset by a register write, so a new code takes effect
  // at once without a restart glitch guard
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q  <= {`LMC_DIV_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= clk32k_tick;
      if (clk32k_tick && !tick_q)
        div_q <= div_q + 1'b1; // R19
    end
  end

  // Tap select: divider bit n toggles at 32768 / 2^(n+1) Hz
  // Codes 4 and up map linearly onto taps 2 to 13
  // Codes 1 to 3 are irregular and get their own taps
  reg sq_tap;
  always @* begin
    case (square_freq_field)
      4'h1:    sq_tap = div_q[6];  // 256 Hz
      4'h2:    sq_tap = div_q[7];  // 128 Hz
      4'h3:    sq_tap = div_q[1];  // 8192 Hz
      4'h0:    sq_tap = 1'b0;      // Held low
      default: sq_tap = div_q[square_freq_field - 4'h2]; // 4096 down to 2 Hz
    endcase
  end

  // Registered pin; low when function not selected
  // One clock of delay is harmless at these frequencies
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      rtc_interrupt_pin <= 1'b0;
    else
      rtc_interrupt_pin <= square_pin_function_select && sq_tap; // R19 R20
  end

endmodule // lmc_misc_bank
